/* File: design/sdt_map.svh */
// Purpose: constants for the skip-decrement and table lookup execution block
// Assumes: 8-bit data path, 16-bit table address
// Notes: program word width is a plain default
`ifndef SDT_MAP_SVH
`define SDT_MAP_SVH
`define SDT_DATA_W 8
`define SDT_ADDR_W 16
`define SDT_PWORD_W 16
`define SDT_HIGH_W 8
`define SDT_LOOKUP_CYCLES 2
`define SDT_PTR_RESET 8'h00
`define SDT_DATH_RESET 8'h00
`endif

/* File: design/sdt_pkg.sv */
// Purpose: types for the skip-decrement and table lookup execution block
// Assumes: sdt_map.svh included for widths
// Notes: none
`include "sdt_map.svh"
package sdt_pkg;
   typedef enum logic [2:0] {
      SDT_OP_NONE = 3'h0,
      SDT_OP_DEC_ACC = 3'h1,
      SDT_OP_DEC_REG = 3'h2,
      SDT_OP_LOOKUP = 3'h3,
      SDT_OP_WR_PTRH = 3'h4,
      SDT_OP_WR_PTRL = 3'h5
   } sdt_op_t;

   typedef struct packed {
      sdt_op_t op;
      logic [`SDT_DATA_W-1:0] operand;
      logic [`SDT_DATA_W-1:0] accumulator;
   } sdt_req_t;

   typedef struct packed {
      logic acc_we;
      logic reg_we;
      logic [`SDT_DATA_W-1:0] data;
      logic skip;
   } sdt_res_t;

   typedef enum logic [1:0] {
      SDT_ST_IDLE = 2'b01,
      SDT_ST_FETCH = 2'b10
   } sdt_state_t;
endpackage : sdt_pkg

/* File: design/sdt_exec.sv */
// Purpose: execution of decrement-skip and program-table lookup operations
// Assumes: one request per instruction cycle, taken when ready is high
// Notes: pointer and high-data registers live here
`timescale 1ns/100ps
`include "sdt_map.svh"
module sdt_exec (
   input wire logic clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire sdt_pkg::sdt_req_t req,
   output logic req_ready,
   output logic pm_rd,
   output logic [`SDT_ADDR_W-1:0] pm_addr,
   input wire logic [`SDT_PWORD_W-1:0] pm_data,
   output sdt_pkg::sdt_res_t res_ff,
   output logic res_valid_ff,
   output logic discard_ff,
   output logic [`SDT_DATA_W-1:0] lookup_pointer_high,
   output logic [`SDT_DATA_W-1:0] lookup_pointer_low,
   output logic [`SDT_HIGH_W-1:0] lookup_data_high
);
   // ============================================================
   // declarations
   // ============================================================
   sdt_pkg::sdt_state_t state_ff;
   sdt_pkg::sdt_state_t nxt_state;
   sdt_pkg::sdt_res_t nxt_res;
   logic nxt_res_valid;
   logic nxt_discard;
   logic [`SDT_DATA_W-1:0] ptrh_ff;
   logic [`SDT_DATA_W-1:0] nxt_ptrh;
   logic [`SDT_DATA_W-1:0] ptrl_ff;
   logic [`SDT_DATA_W-1:0] nxt_ptrl;
   logic [`SDT_HIGH_W-1:0] dath_ff;
   logic [`SDT_HIGH_W-1:0] nxt_dath;
   logic [`SDT_DATA_W-1:0] diff;
   logic [`SDT_DATA_W-1:0] borrow;
   logic diff_zero;
   logic take;
   logic in_fetch;
   logic do_dec_acc;
   logic do_dec_reg;
   logic do_lookup;
   logic do_wr_ptrh;
   logic do_wr_ptrl;

   // ============================================================
   // handshake and program memory side
   // ============================================================
   // lookup stalls the request side for its second cycle; a request
   // offered then is left waiting, not dropped
   assign in_fetch = (state_ff == sdt_pkg::SDT_ST_FETCH);
   assign req_ready = (state_ff == sdt_pkg::SDT_ST_IDLE);
   assign take = req_valid && req_ready;
   assign pm_addr = {ptrh_ff, ptrl_ff};
   assign pm_rd = do_lookup;
   assign lookup_pointer_high = ptrh_ff;
   assign lookup_pointer_low = ptrl_ff;
   assign lookup_data_high = dath_ff;

   // ============================================================
   // operation decode
   // ============================================================
   // only a taken request decodes; spare codes do nothing
   always_comb begin
      do_dec_acc = 1'b0;
      do_dec_reg = 1'b0;
      do_lookup = 1'b0;
      do_wr_ptrh = 1'b0;
      do_wr_ptrl = 1'b0;
      if (take) begin
         unique case (req.op)
            sdt_pkg::SDT_OP_NONE: begin
            end
            sdt_pkg::SDT_OP_DEC_ACC: begin
               do_dec_acc = 1'b1;
            end
            sdt_pkg::SDT_OP_DEC_REG: begin
               do_dec_reg = 1'b1;
            end
            sdt_pkg::SDT_OP_LOOKUP: begin
               do_lookup = 1'b1;
            end
            sdt_pkg::SDT_OP_WR_PTRH: begin
               do_wr_ptrh = 1'b1;
            end
            sdt_pkg::SDT_OP_WR_PTRL: begin
               do_wr_ptrl = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // ============================================================
   // decrement by one
   // ============================================================
   // ripple borrow, one stage per bit; the borrow out of the top bit is
   // dropped, so an operand of zero wraps to all ones
   assign borrow[0] = 1'b1;
   for (genvar i = 0; i < `SDT_DATA_W; i++) begin : g_dec_bit
      assign diff[i] = req.operand[i] ^ borrow[i];
      if (i < `SDT_DATA_W - 1) begin : g_borrow
         assign borrow[i+1] = borrow[i] & ~req.operand[i];
      end
   end
   assign diff_zero = (diff == '0);

   // ============================================================
   // control and result: next values
   // ============================================================
   always_comb begin
      nxt_state = state_ff;
      nxt_res = '0;
      nxt_res_valid = 1'b0;
      nxt_discard = 1'b0;
      unique case (state_ff)
         sdt_pkg::SDT_ST_IDLE: begin
            if (do_dec_acc) begin
               nxt_res.acc_we = 1'b1;
               nxt_res.data = diff;
               nxt_res.skip = diff_zero;
               nxt_res_valid = 1'b1;
            end
            if (do_dec_reg) begin
               nxt_res.reg_we = 1'b1;
               nxt_res.data = diff;
               nxt_res.skip = diff_zero;
               nxt_res_valid = 1'b1;
            end
            // the skip is only flagged: the core throws away the
            // instruction it already fetched, which is the second cycle
            nxt_discard = (do_dec_acc || do_dec_reg) && diff_zero;
            if (do_lookup) begin
               nxt_state = sdt_pkg::SDT_ST_FETCH;
            end
         end
         sdt_pkg::SDT_ST_FETCH: begin
            // the word answers one cycle after the read strobe
            nxt_res.reg_we = 1'b1;
            nxt_res.data = pm_data[`SDT_DATA_W-1:0];
            nxt_res_valid = 1'b1;
            nxt_state = sdt_pkg::SDT_ST_IDLE;
         end
         default: begin
            nxt_state = sdt_pkg::SDT_ST_IDLE;
         end
      endcase
   end

   // ============================================================
   // control and result: registers
   // ============================================================
   always_ff @(posedge clk) begin
      if (srst) begin
         state_ff <= sdt_pkg::SDT_ST_IDLE;
         res_ff <= '0;
         res_valid_ff <= 1'b0;
         discard_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         res_ff <= nxt_res;
         res_valid_ff <= nxt_res_valid;
         discard_ff <= nxt_discard;
      end
   end

   // ============================================================
   // lookup pointers
   // ============================================================
   // both bytes load from the accumulator; the pair holds until rewritten
   always_comb begin
      nxt_ptrh = ptrh_ff;
      nxt_ptrl = ptrl_ff;
      if (do_wr_ptrh) begin
         nxt_ptrh = req.accumulator;
      end
      if (do_wr_ptrl) begin
         nxt_ptrl = req.accumulator;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ptrh_ff <= `SDT_PTR_RESET;
         ptrl_ff <= `SDT_PTR_RESET;
      end else begin
         ptrh_ff <= nxt_ptrh;
         ptrl_ff <= nxt_ptrl;
      end
   end

   // ============================================================
   // high part of the fetched word
   // ============================================================
   // there is no valid strobe on the memory side, so the fetch state
   // alone marks the cycle in which the word stands
   always_comb begin
      nxt_dath = dath_ff;
      if (in_fetch) begin
         nxt_dath = `SDT_HIGH_W'(pm_data >> `SDT_DATA_W);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         dath_ff <= `SDT_DATH_RESET;
      end else begin
         dath_ff <= nxt_dath;
      end
   end
endmodule : sdt_exec

/* File: sim/sdt_exec_assertions.sv */
// Purpose: port checks for sdt_exec
// Assumes: one clock, sync reset
// Notes: bound after the module
`timescale 1ns/100ps
module sdt_exec_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic req_valid,
   input wire sdt_pkg::sdt_req_t req,
   input wire logic req_ready,
   input wire logic pm_rd,
   input wire sdt_pkg::sdt_res_t res_ff,
   input wire logic res_valid_ff,
   input wire logic discard_ff,
   input wire logic [15:0] pm_data,
   input wire logic [7:0] lookup_pointer_high,
   input wire logic [7:0] lookup_pointer_low,
   input wire logic [7:0] lookup_data_high
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire tk = req_valid & req_ready;
   wire [2:0] op = req.op;
   sequence s_fetch;
      pm_rd ##1 !req_ready ##1 res_valid_ff && res_ff.reg_we;
   endsequence
   a_lookup_steps: assert property (tk && op == 3'h3 |-> s_fetch)
      else $error("lookup steps wrong");
   a_dec_acc: assert property (tk && op == 3'h1 |=> res_ff.acc_we &&
      res_ff.data == $past(req.operand) - 8'h01) else $error("dec acc bad");
   a_dec_place: assert property (tk && op == 3'h2 |=> res_ff.reg_we &&
      res_ff.data == $past(req.operand) - 8'h01) else $error("dec reg bad");
   a_skip_zero: assert property (tk && op inside {3'h1, 3'h2} |=>
      res_ff.skip == ($past(req.operand) == 8'h01)) else $error("skip bad");
   a_one_cycle: assert property (tk && op inside {3'h1, 3'h2} |=>
      req_ready && res_valid_ff && discard_ff == res_ff.skip)
      else $error("dec timing bad");
   a_high_byte: assert property (!req_ready |=>
      lookup_data_high == $past(pm_data[15:8]) &&
      res_ff.data == $past(pm_data[7:0])) else $error("lookup word bad");
   a_ptr_high: assert property (tk && op == 3'h4 |=>
      lookup_pointer_high == $past(req.accumulator))
      else $error("pointer high bad");
   a_ptr_low: assert property (tk && op == 3'h5 |=>
      lookup_pointer_low == $past(req.accumulator))
      else $error("pointer low bad");
endmodule : sdt_exec_chk
bind sdt_exec sdt_exec_chk chk_i (
   .clk(clk),
   .srst(srst),
   .req_valid(req_valid),
   .req(req),
   .req_ready(req_ready),
   .pm_rd(pm_rd),
   .res_ff(res_ff),
   .res_valid_ff(res_valid_ff),
   .discard_ff(discard_ff),
   .pm_data(pm_data),
   .lookup_pointer_high(lookup_pointer_high),
   .lookup_pointer_low(lookup_pointer_low),
   .lookup_data_high(lookup_data_high)
);

/* File: sim/sdt_exec_tb_top.sv */
// Purpose: bench for sdt_exec
// Assumes: inputs move 1 ns after clk rises
// Notes: lfsr seed 8'h51
`timescale 1ns/100ps
module sdt_exec_tb_top;
   logic clk = 1'b0, srst = 1'b1, req_valid = 1'b0;
   logic req_ready, pm_rd, res_valid_ff, discard_ff;
   logic [7:0] lookup_pointer_high, lookup_pointer_low, lookup_data_high;
   logic [15:0] pm_addr, w, pm_data = 16'h0000;
   logic [7:0] lf = 8'h51;
   sdt_pkg::sdt_req_t req = '0;
   sdt_pkg::sdt_res_t res_ff;
   int n_errors = 0, checked = 0;
   always #50 clk = ~clk;
   sdt_exec uut (
      .clk(clk),
      .srst(srst),
      .req_valid(req_valid),
      .req(req),
      .req_ready(req_ready),
      .pm_rd(pm_rd),
      .pm_addr(pm_addr),
      .pm_data(pm_data),
      .res_ff(res_ff),
      .res_valid_ff(res_valid_ff),
      .discard_ff(discard_ff),
      .lookup_pointer_high(lookup_pointer_high),
      .lookup_pointer_low(lookup_pointer_low),
      .lookup_data_high(lookup_data_high)
   );
   function automatic logic [7:0] nxt(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : nxt
   function automatic logic [10:0] dec(logic q, logic a, logic [7:0] v);
      return q ? {a, ~a, v - 8'h01, v == 8'h01} : 11'h000;
   endfunction : dec
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic step(logic [18:0] r);
      req = r;
      @(posedge clk);
      #1;
   endtask : step
   task automatic final_report;
      if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   initial begin
      #100000 n_errors++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 srst = 1'b0;
      req_valid = 1'b1;
      chk("ptr", 16'h0000, pm_addr);
      // corner operands 0..3 first: wrap and the skip case
      for (int i = 0; i < 40; i++) begin
         lf = nxt(lf);
         w = i < 4 ? 16'(i) : {8'h00, lf};
         // an idle request line now and then must yield nothing
         req_valid = i < 4 || lf[1];
         step({3'h1 + lf[0], w[7:0], 8'h00});
         chk("dec", dec(req_valid, ~lf[0], w[7:0]), res_ff);
         chk("skip", req_valid && w == 16'h0001, discard_ff);
         chk("valid", req_valid, res_valid_ff);
      end
      req_valid = 1'b1;
      for (int i = 0; i < 6; i++) begin
         w = {nxt(lf), lf};
         step({3'h4, 8'h00, w[15:8]});
         chk("ptrh", w[15:8], lookup_pointer_high);
         step({3'h5, 8'h00, w[7:0]});
         chk("addr", w, pm_addr);
         chk("ptrl", w[7:0], lookup_pointer_low);
         req = {3'h3, 16'h0000};
         @(negedge clk);
         chk("rd", 16'h0001, pm_rd);
         step({3'h3, 16'h0000});
         pm_data = {w[7:0] ^ 8'hA5, w[15:8]};
         chk("ready", 16'h0000, req_ready);
         // a decrement offered in the fetch cycle must not be taken
         step({3'h1, 16'h0101});
         chk("table", {2'b01, pm_data[7:0], 1'b0}, res_ff);
         chk("high", pm_data[15:8], lookup_data_high);
         lf = w[15:8];
      end
      final_report();
   end
endmodule : sdt_exec_tb_top
